// ### rtl/vcp_fifo2.sv
// Two-entry byte buffer between the transmit sequencer and the highway.
`timescale 1ns/10ps
module vcp_fifo2
	import vcp_pkg::*;
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Filling side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [FIFO_W-1:0] in_data,
	// Draining side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [FIFO_W-1:0] out_data
);

	typedef struct packed {
		logic [1:0][FIFO_W-1:0] mem;
		logic wptr;
		logic rptr;
		logic [1:0] count;
	} vcp_fifo_s;

	vcp_fifo_s st;
	vcp_fifo_s nxt;
	logic push;
	logic pop;

	// Full and empty come straight from the count, so neither side can be fooled.
	assign in_ready = (st.count != 2'h2);
	assign out_valid = (st.count != 2'h0);
	assign out_data = st.mem[st.rptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointer and count update; push and pop may happen in the same cycle.
	always_comb
	begin
		nxt = st;
		if (push)
		begin
			nxt.mem[st.wptr] = in_data;
			nxt.wptr = ~st.wptr;
		end
		if (pop)
		begin
			nxt.rptr = ~st.rptr;
		end
		nxt.count = 2'(st.count + {1'b0, push} - {1'b0, pop});
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '0;
		end
		else
		begin
			st <= nxt;
		end
	end

endmodule : vcp_fifo2

// ### rtl/vcp_pkg.sv
// Shared constants and types of the voice codec digital path.
package vcp_pkg;

	// Data widths and arithmetic scaling.
	localparam int unsigned SAMPLE_W = 16;
	localparam int unsigned CODE_W = 8;
	localparam int unsigned EQ_TAPS = 4;
	localparam int unsigned GAIN_SHIFT = 14;
	localparam int unsigned HPF_SHIFT = 5;
	localparam int unsigned FIFO_W = 8;

	// Register byte addresses on the APB.
	localparam int unsigned ADDR_W = 12;
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_TX_GAIN = 12'h004;
	localparam logic [11:0] ADDR_RX_GAIN = 12'h008;
	localparam logic [11:0] ADDR_STATUS = 12'h00c;
	localparam logic [11:0] ADDR_TX_EQ = 12'h010;
	localparam logic [11:0] ADDR_RX_EQ = 12'h020;

	// Bit positions in the digital control register.
	localparam int unsigned CTRL_W = 6;
	localparam int unsigned CTRL_TX_MUTE = 0;
	localparam int unsigned CTRL_RX_MUTE = 1;
	localparam int unsigned CTRL_MU_LAW = 2;
	localparam int unsigned CTRL_COMPAND = 3;
	localparam int unsigned CTRL_BYPASS = 4;
	localparam int unsigned CTRL_TONE_EN = 5;

	// Bit positions in the status register.
	localparam int unsigned STAT_TX_BUSY = 0;
	localparam int unsigned STAT_RX_HALF = 1;
	localparam int unsigned STAT_TX_ROOM = 2;
	localparam int unsigned STAT_RX_SAMPLE = 16;

	// Reset values and the mute level.
	localparam logic [5:0] CTRL_RST = 6'h00;
	localparam logic [15:0] GAIN_UNITY = 16'h4000;
	localparam logic [15:0] GAIN_MUTE = 16'h0000;

	// Companding and saturation constants.
	localparam logic [15:0] MU_BIAS = 16'h0084;
	localparam logic [15:0] MU_CLIP = 16'h7f7b;
	localparam logic [7:0] A_TOGGLE = 8'h55;
	localparam logic [15:0] A_SEG_ONE = 16'h0100;
	localparam logic [15:0] SAT_MAX = 16'h7fff;
	localparam logic [15:0] SAT_MIN = 16'h8000;

	// Transmit byte sequencer states.
	typedef enum logic [2:0] {
		VCP_TX_IDLE = 3'b001,
		VCP_TX_HIGH = 3'b010,
		VCP_TX_LOW = 3'b100
	} vcp_tx_state_e;

endpackage : vcp_pkg

// ### rtl/vcp_top.sv
// Voice codec digital path: transmit and receive sample processing with an APB register file.
// Functional notes
// R1: Transmit input is one 16-bit linear converter sample per 8 kHz period, taken before filtering.
// R2: A first-order digital high-pass filter removes low-frequency content from transmit samples.
// R3: Each direction has a 4-tap equalizer fed from its own four coefficient registers.
// R4: Gain multiplies by a coefficient in 1/16384 units: 0 mutes, 4000h is unity, 7FFFh about +6 dB.
// R5: Transmit and receive gain coefficients are held in separate, independently written registers.
// R6: Post-gain linear transmit samples go to the tone decoder only while tone detection is enabled.
// R7: The last transmit step optionally compresses each sample to an 8-bit A-law or mu-law code.
// R8: Compressed samples occupy one highway slot, linear samples two slots, high byte first.
// R9: Received 8-bit codes are expanded to 16-bit linear samples with the selected law.
// R10: With format bypass set, two successive received bytes form one linear sample, high first.
// R11: The converter output gets one 16-bit sample per frame after equalizer and gain.
// R12: Two mute bits silence transmit and receive without touching the gain coefficients.
// R13: Multiplier results saturate to the signed 16-bit range instead of wrapping.
// R14: One law-select bit sets the companding law for both directions.
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/10ps
module vcp_top
	import vcp_pkg::*;
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB register port.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Converter sample input.
	input wire logic adc_valid,
	output logic adc_ready,
	input wire logic [SAMPLE_W-1:0] adc_data,
	// Tone decoder feed.
	output logic tone_valid,
	output logic [SAMPLE_W-1:0] tone_data,
	// Highway transmit bytes.
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [CODE_W-1:0] tx_data,
	// Highway receive bytes.
	input wire logic rx_valid,
	input wire logic [CODE_W-1:0] rx_data,
	// Frame strobe pin.
	input wire logic frame_sync,
	// Converter sample output.
	output logic dac_valid,
	output logic [SAMPLE_W-1:0] dac_data
);

	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [15:0] tx_gain;
		logic [15:0] rx_gain;
		logic [3:0][15:0] tx_eq;
		logic [3:0][15:0] rx_eq;
		logic [15:0] tx_x1;
		logic [15:0] tx_y1;
		logic [3:0][15:0] tx_hist;
		logic [15:0] tx_word;
		vcp_tx_state_e tx_st;
		logic tone_valid;
		logic [15:0] tone_data;
		logic [7:0] rx_hi;
		logic rx_half;
		logic [3:0][15:0] rx_hist;
		logic [15:0] rx_out;
		logic fs_meta;
		logic fs_sync;
		logic fs_prev;
		logic dac_valid;
		logic [15:0] dac_data;
	} vcp_state_s;

	vcp_state_s st;
	vcp_state_s nxt;

	// Saturate a wide signed value into 16 bits.
	function automatic logic [15:0] sat16(input logic signed [35:0] v);
		if (v[35:15] != {21{v[35]}})
		begin
			return v[35] ? SAT_MIN : SAT_MAX; // [R13]
		end
		return v[15:0];
	endfunction : sat16

	// Four-tap FIR; index 0 holds the newest sample.
	function automatic logic [15:0] eq_apply(input logic [3:0][15:0] h, input logic [3:0][15:0] c);
		logic signed [35:0] acc;
		acc = '0;
		for (int k = 0; k < EQ_TAPS; k++)
		begin
			acc = acc + 36'($signed(h[k]) * $signed(c[k])); // [R3]
		end
		return sat16(acc >>> GAIN_SHIFT);
	endfunction : eq_apply

	// The coefficient is unsigned, so a zero extension keeps 7FFFh positive.
	function automatic logic [15:0] gain_apply(input logic [15:0] x, input logic [15:0] g);
		logic signed [35:0] p;
		p = 36'($signed(x) * $signed({1'b0, g})); // [R4]
		return sat16(p >>> GAIN_SHIFT); // [R13]
	endfunction : gain_apply

	// Linear to mu-law.
	function automatic logic [7:0] mu_encode(input logic [15:0] s);
		logic [15:0] mag;
		logic [2:0] seg;
		mag = s[15] ? 16'(-s) : s;
		if (mag > MU_CLIP)
		begin
			mag = MU_CLIP;
		end
		mag = 16'(mag + MU_BIAS);
		seg = 3'h0;
		for (int i = 0; i < 8; i++)
		begin
			if (mag[i + 7])
			begin
				seg = 3'(i);
			end
		end
		return ~{s[15], seg, 4'(mag >> (seg + 3))};
	endfunction : mu_encode

	// Mu-law to linear.
	function automatic logic [15:0] mu_decode(input logic [7:0] code);
		logic [7:0] c;
		logic [15:0] t;
		c = ~code;
		t = 16'(({9'h0, c[3:0], 3'h0} + MU_BIAS) << c[6:4]);
		return c[7] ? 16'(MU_BIAS - t) : 16'(t - MU_BIAS);
	endfunction : mu_decode

	// Linear to A-law on a 12-bit magnitude.
	function automatic logic [7:0] a_encode(input logic [15:0] s);
		logic [15:0] mag;
		logic [11:0] ix;
		logic [2:0] seg;
		mag = s[15] ? 16'(-s) : s;
		ix = mag[15] ? 12'hfff : mag[14:3];
		seg = 3'h0;
		for (int i = 5; i < 12; i++)
		begin
			if (ix[i])
			begin
				seg = 3'(i - 4);
			end
		end
		if (seg == 3'h0)
		begin
			return {~s[15], seg, ix[4:1]} ^ A_TOGGLE;
		end
		return {~s[15], seg, 4'(ix >> seg)} ^ A_TOGGLE;
	endfunction : a_encode

	// A-law to linear.
	function automatic logic [15:0] a_decode(input logic [7:0] code);
		logic [7:0] c;
		logic [15:0] t;
		c = code ^ A_TOGGLE;
		t = {8'h00, c[3:0], 4'h8};
		if (c[6:4] != 3'h0)
		begin
			t = 16'((t + A_SEG_ONE) << (c[6:4] - 3'h1));
		end
		return c[7] ? t : 16'(-t);
	endfunction : a_decode

	logic signed [35:0] hp_sum;
	logic [15:0] hp_out;
	logic [3:0][15:0] tx_hist_new;
	logic [15:0] tx_gained;
	logic [15:0] tx_lin;
	logic [15:0] rx_word;
	logic rx_word_ok;
	logic [3:0][15:0] rx_hist_new;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic [7:0] fifo_in_data;
	logic apb_access;
	logic apb_write;
	logic eq_hit_tx;
	logic eq_hit_rx;
	logic [1:0] eq_idx;

	// Transmit datapath from converter sample to gain output.
	always_comb
	begin
		hp_sum = 36'($signed(adc_data)) - 36'($signed(st.tx_x1)) + 36'($signed(st.tx_y1))
			- (36'($signed(st.tx_y1)) >>> HPF_SHIFT); // [R2]
		hp_out = sat16(hp_sum);
		tx_hist_new = {st.tx_hist[2:0], hp_out}; // [R1]
		tx_gained = gain_apply(eq_apply(tx_hist_new, st.tx_eq), st.tx_gain); // [R3] [R5]
		tx_lin = st.ctrl[CTRL_TX_MUTE] ? GAIN_MUTE : tx_gained; // [R12]
	end

	// Receive byte assembly or expansion into a linear word.
	always_comb
	begin
		rx_word_ok = 1'b0;
		rx_word = '0;
		if (rx_valid)
		begin
			if (st.ctrl[CTRL_BYPASS])
			begin
				rx_word_ok = st.rx_half; // [R10]
				rx_word = {st.rx_hi, rx_data};
			end
			else
			begin
				rx_word_ok = 1'b1;
				rx_word = st.ctrl[CTRL_MU_LAW] ? mu_decode(rx_data) : a_decode(rx_data); // [R9] [R14]
			end
		end
		rx_hist_new = {st.rx_hist[2:0], rx_word};
	end

	// The slave answers at once, so the access phase is always one cycle.
	assign pready = 1'b1;
	assign apb_access = psel && penable;
	assign apb_write = apb_access && pwrite;
	assign eq_hit_tx = (paddr[ADDR_W-1:4] == ADDR_TX_EQ[ADDR_W-1:4]);
	assign eq_hit_rx = (paddr[ADDR_W-1:4] == ADDR_RX_EQ[ADDR_W-1:4]);
	assign eq_idx = paddr[3:2];
	assign adc_ready = (st.tx_st == VCP_TX_IDLE);
	assign fifo_in_valid = (st.tx_st != VCP_TX_IDLE);
	assign fifo_in_data = (st.tx_st == VCP_TX_HIGH) ? st.tx_word[15:8] : st.tx_word[7:0]; // [R8]
	assign tone_valid = st.tone_valid;
	assign tone_data = st.tone_data;
	assign dac_valid = st.dac_valid;
	assign dac_data = st.dac_data;

	// Next-state logic for registers, sequencer, receive path and frame timing.
	always_comb
	begin
		nxt = st;
		nxt.tone_valid = 1'b0;
		nxt.dac_valid = 1'b0;
		prdata = '0;
		pslverr = 1'b0;

		// Register reads and writes; an unknown address, or a mis-aligned one outside the equalizer windows, errors.
		if (eq_hit_tx || eq_hit_rx)
		begin
			prdata = {16'h0000, eq_hit_tx ? st.tx_eq[eq_idx] : st.rx_eq[eq_idx]};
			if (apb_write && eq_hit_tx)
			begin
				nxt.tx_eq[eq_idx] = pwdata[15:0]; // [R3]
			end
			if (apb_write && eq_hit_rx)
			begin
				nxt.rx_eq[eq_idx] = pwdata[15:0]; // [R3]
			end
		end
		else
		begin
			unique case (paddr)
				ADDR_CTRL:
				begin
					prdata = {26'h0, st.ctrl};
					if (apb_write)
					begin
						nxt.ctrl = pwdata[CTRL_W-1:0]; // [R12] [R14]
					end
				end
				ADDR_TX_GAIN:
				begin
					prdata = {16'h0000, st.tx_gain};
					if (apb_write)
					begin
						nxt.tx_gain = pwdata[15:0]; // [R5]
					end
				end
				ADDR_RX_GAIN:
				begin
					prdata = {16'h0000, st.rx_gain};
					if (apb_write)
					begin
						nxt.rx_gain = pwdata[15:0]; // [R5]
					end
				end
				ADDR_STATUS:
				begin
					prdata[STAT_TX_BUSY] = (st.tx_st != VCP_TX_IDLE);
					prdata[STAT_RX_HALF] = st.rx_half;
					prdata[STAT_TX_ROOM] = fifo_in_ready;
					prdata[STAT_RX_SAMPLE +: SAMPLE_W] = st.rx_out;
				end
				default:
				begin
					pslverr = apb_access;
				end
			endcase
		end

		// Transmit capture and byte sequencing toward the buffer.
		unique case (st.tx_st)
			VCP_TX_IDLE:
			begin
				if (adc_valid)
				begin
					nxt.tx_x1 = adc_data;
					nxt.tx_y1 = hp_out;
					nxt.tx_hist = tx_hist_new;
					nxt.tone_valid = st.ctrl[CTRL_TONE_EN]; // [R6]
					nxt.tone_data = tx_gained;
					if (st.ctrl[CTRL_COMPAND])
					begin
						nxt.tx_word = {8'h00, st.ctrl[CTRL_MU_LAW] ? mu_encode(tx_lin)
							: a_encode(tx_lin)}; // [R7] [R14]
						nxt.tx_st = VCP_TX_LOW; // [R8]
					end
					else
					begin
						nxt.tx_word = tx_lin;
						nxt.tx_st = VCP_TX_HIGH; // [R8]
					end
				end
			end
			VCP_TX_HIGH:
			begin
				if (fifo_in_ready)
				begin
					nxt.tx_st = VCP_TX_LOW;
				end
			end
			VCP_TX_LOW:
			begin
				if (fifo_in_ready)
				begin
					nxt.tx_st = VCP_TX_IDLE;
				end
			end
		endcase

		// Receive pairing; leaving bypass drops a half-built word.
		if (rx_valid && st.ctrl[CTRL_BYPASS])
		begin
			nxt.rx_hi = rx_data;
			nxt.rx_half = ~st.rx_half; // [R10]
		end
		if (!st.ctrl[CTRL_BYPASS])
		begin
			nxt.rx_half = 1'b0;
		end
		if (rx_word_ok)
		begin
			nxt.rx_hist = rx_hist_new;
			nxt.rx_out = gain_apply(eq_apply(rx_hist_new, st.rx_eq), st.rx_gain); // [R3] [R5]
		end

		// Frame pin synchroniser and once-per-frame converter update.
		nxt.fs_meta = frame_sync;
		nxt.fs_sync = st.fs_meta;
		nxt.fs_prev = st.fs_sync;
		if (st.fs_sync && !st.fs_prev)
		begin
			nxt.dac_valid = 1'b1; // [R11]
			nxt.dac_data = st.ctrl[CTRL_RX_MUTE] ? GAIN_MUTE : st.rx_out; // [R12]
		end
	end

	// State register with documented reset values.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '0;
			st.ctrl <= CTRL_RST;
			st.tx_gain <= GAIN_UNITY;
			st.rx_gain <= GAIN_UNITY;
			st.tx_eq[0] <= GAIN_UNITY;
			st.rx_eq[0] <= GAIN_UNITY;
			st.tx_st <= VCP_TX_IDLE;
		end
		else
		begin
			st <= nxt;
		end
	end

	// The buffer lets the highway stall for a sample without losing a byte.
	vcp_fifo2 u_tx_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data(tx_data)
	);

endmodule : vcp_top

// ### test/testbench.sv
// Self-checking bench for the voice codec digital path.
`timescale 1ns/10ps
module testbench
	import vcp_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic adc_valid = 1'b0, stall = 1'b0, pready, pslverr, adc_ready, tone_valid, tx_valid;
	logic tx_ready, rx_valid, frame_sync, dac_valid, err;
	logic [ADDR_W-1:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd_data;
	logic [15:0] adc_data = 16'h0000, tone_data, dac_data, r;
	logic [7:0] tx_data, rx_data;
	logic [15:0] q_dac[$], q_tone[$];
	logic [7:0] q_tx[$];
	int mismatches = 0, n_checks = 0;
	// Register reset table and expansion table.
	logic [11:0] ra[7] = '{12'h000, 12'h004, 12'h008, 12'h010, 12'h01c, 12'h020, 12'h02c};
	logic [15:0] rv[7] = '{16'h0, 16'h4000, 16'h4000, 16'h4000, 16'h0, 16'h4000, 16'h0};
	logic [7:0] xc[4] = '{8'hd5, 8'haa, 8'hff, 8'h80};
	logic [15:0] xv[4] = '{16'h0008, 16'h7e00, 16'h0000, 16'h7d7c};

	vcp_top vcp_top_inst (.*);
	vcp_hwy_model vcp_hwy_model_inst (.*);

	// Free-running 40 MHz clock.
	always #12.5 pclk = ~pclk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out

	// One APB transfer; request held until pready is sampled high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge pclk);
			i++;
		end
		while (pready !== 1'b1 && i < 50);
		if (i >= 50)
		begin
			mismatches++;
			close_out();
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rd_data);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'b0, a, 32'h0, rd_data);
		check(rd_data & m, e);
	endtask : rd

	task automatic do_reset();
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
	endtask : do_reset

	// Offer one converter sample and hold it until taken.
	task automatic adc(input logic [15:0] x);
		int i;
		@(posedge pclk);
		adc_valid <= 1'b1;
		adc_data <= x;
		i = 0;
		do
		begin
			@(posedge pclk);
			i++;
		end
		while (adc_ready !== 1'b1 && i < 300);
		if (i >= 300)
		begin
			mismatches++;
			close_out();
		end
		adc_valid <= 1'b0;
	endtask : adc

	// Check the processed receive sample, then let a frame deliver it.
	task automatic rx_exp(input logic [15:0] st, input logic [15:0] da, input logic [15:0] m);
		rd(ADDR_STATUS, {st, 16'h0}, {m, 16'h0});
		q_dac.push_back(da);
		vcp_hwy_model_inst.frame();
	endtask : rx_exp

	task automatic rxw(input logic [15:0] w, input logic [15:0] st, input logic [15:0] da,
		input logic [15:0] m);
		vcp_hwy_model_inst.word(w);
		rx_exp(st, da, m);
	endtask : rxw

	task automatic tx_case(input logic [31:0] c, input logic [15:0] x, input int n,
		input logic [7:0] b);
		wr(ADDR_CTRL, c);
		q_tone.push_back(x);
		repeat (n) q_tx.push_back(b);
		adc(x);
	endtask : tx_case

	// Results are matched in order against the notes left by the drivers.
	always @(posedge pclk)
	begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
			check(tx_data, q_tx.size() ? q_tx.pop_front() : 8'hxx);
		if (dac_valid === 1'b1)
			check(dac_data, q_dac.size() ? q_dac.pop_front() : 16'hxxxx);
		if (tone_valid === 1'b1)
			check(tone_data, q_tone.size() ? q_tone.pop_front() : 16'hxxxx);
	end

	initial
	begin
		void'($urandom(32'hf155));
		do_reset();
		for (int i = 0; i < 7; i++)
			rd(ra[i], rv[i], 32'hffff_ffff);
		apb(1'b0, 12'h040, 32'h0, rd_data);
		check({err, rd_data[30:0]}, 32'h8000_0000);
		// Stall the highway: the buffer fills and intake stops, yet no byte is lost.
		stall <= 1'b1;
		q_tx = '{8'h04, 8'h00, 8'hff, 8'he0, 8'hff, 8'he1};
		fork
			begin
				adc(16'h0400);
				adc(16'h0000);
				adc(16'h0000);
			end
			begin
				repeat (30) @(posedge pclk);
				check(adc_ready, 1'b0);
				rd(ADDR_STATUS, 32'h0, 32'h0000_0004);
				stall <= 1'b0;
			end
		join
		wr(ADDR_TX_GAIN, 32'h1234);
		rd(ADDR_TX_GAIN, 32'h1234, 32'hffff_ffff);
		rd(ADDR_RX_GAIN, 32'h4000, 32'hffff_ffff);
		// Bypass assembly, random words, mute, gain extremes and equalizer delay.
		wr(ADDR_CTRL, 32'h10);
		vcp_hwy_model_inst.slot(8'h5a);
		rd(ADDR_STATUS, 32'h2, 32'h2);
		vcp_hwy_model_inst.slot(8'h3c);
		rx_exp(16'h5a3c, 16'h5a3c, 16'hffff);
		repeat (4)
		begin
			r = 16'($urandom);
			rxw(r, r, r, 16'hffff);
		end
		wr(ADDR_CTRL, 32'h12);
		rxw(16'h1357, 16'h1357, 16'h0000, 16'hffff);
		rd(ADDR_RX_GAIN, 32'h4000, 32'hffff_ffff);
		wr(ADDR_CTRL, 32'h10);
		wr(ADDR_RX_GAIN, 32'h0);
		rxw(16'h2468, 16'h0000, 16'h0000, 16'hffff);
		wr(ADDR_RX_GAIN, 32'h7fff);
		rxw(16'h6000, 16'h7fff, 16'h7fff, 16'hffff);
		rxw(16'ha000, 16'h8000, 16'h8000, 16'hffff);
		wr(ADDR_RX_GAIN, 32'h4000);
		wr(ADDR_RX_EQ, 32'h0);
		wr(ADDR_RX_EQ + 12'h004, 32'h4000);
		vcp_hwy_model_inst.word(16'h0c0c);
		rxw(16'h7070, 16'h0c0c, 16'h0c0c, 16'hffff);
		wr(ADDR_RX_EQ, 32'h4000);
		wr(ADDR_RX_EQ + 12'h004, 32'h0);
		// Expansion with both laws.
		for (int i = 0; i < 4; i++)
		begin
			wr(ADDR_CTRL, i < 2 ? 32'h0 : 32'h4);
			vcp_hwy_model_inst.slot(xc[i]);
			rx_exp(xv[i], xv[i], 16'hffff);
		end
		// Second reset clears the filter history for exact transmit codes.
		do_reset();
		tx_case(32'h28, 16'h0000, 1, 8'hd5);
		tx_case(32'h2c, 16'h0000, 1, 8'hff);
		tx_case(32'h21, 16'h1234, 2, 8'h00);
		// Half gain: the filter leaves 4000h after the last sample, so 2000h must come out.
		wr(ADDR_TX_GAIN, 32'h2000);
		wr(ADDR_CTRL, 32'h20);
		q_tone.push_back(16'h2000);
		q_tx.push_back(8'h20);
		q_tx.push_back(8'h00);
		adc(16'h4091);
		for (int i = 0; i < 300 && q_tx.size() + q_tone.size() + q_dac.size() != 0; i++)
			@(posedge pclk);
		check(32'(q_tx.size() + q_tone.size() + q_dac.size()), 32'h0);
		close_out();
	end

	// Hang guard.
	initial
	begin
		#2500000;
		mismatches++;
		close_out();
	end
endmodule : testbench

// ### test/vcp_asserts.sv
// Port-level assertion checker for the voice codec digital path.
`timescale 1ns/10ps
module vcp_chk
	import vcp_pkg::*;
(
	// Clock, reset and register port.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Sample and highway signals.
	input wire logic adc_valid,
	input wire logic adc_ready,
	input wire logic tone_valid,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [CODE_W-1:0] tx_data,
	input wire logic frame_sync,
	input wire logic dac_valid,
	input wire logic [SAMPLE_W-1:0] dac_data
);
	// One clock domain, so all checks share one clock and one reset.
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Register port answers at once; an aligned word is refused only above the map.
	property p_apb_ready;
		psel && penable |-> pready;
	endproperty
	a_apb_ready: assert property (p_apb_ready) else $error("no ready in access");
	property p_apb_err;
		psel && penable && paddr[1:0] == 2'b00
			|-> pslverr == (paddr >= 12'h030) && (!pslverr || prdata == 32'h0);
	endproperty
	a_apb_err: assert property (p_apb_err) else $error("bad error response");

	// Sample intake and byte stream.
	property p_adc_busy;
		adc_valid && adc_ready |=> !adc_ready;
	endproperty
	a_adc_busy: assert property (p_adc_busy) else $error("sample taken too soon");
	property p_adc_out;
		adc_valid && adc_ready |-> ##[1:2] tx_valid;
	endproperty
	a_adc_out: assert property (p_adc_out) else $error("no byte after sample");
	property p_tone_cause;
		tone_valid |-> $past(adc_valid && adc_ready);
	endproperty
	a_tone_cause: assert property (p_tone_cause) else $error("stray tone pulse");
	property p_tx_hold;
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("byte dropped on stall");

	// Converter output: one pulse per frame, data held between frames.
	property p_dac_frame;
		$rose(frame_sync) |-> ##[2:4] dac_valid;
	endproperty
	a_dac_frame: assert property (p_dac_frame) else $error("no output on frame");
	property p_dac_pulse;
		dac_valid |=> !dac_valid [*2];
	endproperty
	a_dac_pulse: assert property (p_dac_pulse) else $error("output pulse too long");
	property p_dac_hold;
		$changed(dac_data) |-> dac_valid;
	endproperty
	a_dac_hold: assert property (p_dac_hold) else $error("output changed off frame");

	// Main scenarios reached.
	c_stall: cover property (tx_valid && !tx_ready);
	c_dac: cover property (dac_valid);
	c_tone: cover property (tone_valid);
	c_err: cover property (psel && penable && pslverr);
endmodule : vcp_chk

bind vcp_top vcp_chk vcp_chk_inst (.*);

// ### test/vcp_hwy_model.sv
// Highway master model: frame strobe, receive slots and transmit back-pressure.
`timescale 1ns/10ps
module vcp_hwy_model
(
	// Clock and stall request from the bench.
	input wire logic pclk,
	input wire logic stall,
	// Highway side.
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic frame_sync,
	output logic tx_ready
);
	// Idle highway at time zero.
	initial
	begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		frame_sync = 1'b0;
		tx_ready = 1'b0;
	end

	// Random back-pressure, so a slow master is exercised throughout.
	always @(posedge pclk)
		tx_ready <= !stall && ($urandom_range(3) != 0);

	// One byte in one slot; afterwards the data line shows the inverse.
	task automatic slot(input logic [7:0] b);
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx_data <= b;
		@(posedge pclk);
		rx_valid <= 1'b0;
		rx_data <= ~b;
	endtask : slot

	// A linear word takes two consecutive slots, high byte first.
	task automatic word(input logic [15:0] w);
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx_data <= w[15:8];
		@(posedge pclk);
		rx_data <= w[7:0];
		@(posedge pclk);
		rx_valid <= 1'b0;
		rx_data <= ~w[7:0];
	endtask : word

	// One frame strobe, long enough for the pin synchroniser.
	task automatic frame();
		@(posedge pclk);
		frame_sync <= 1'b1;
		repeat (4) @(posedge pclk);
		frame_sync <= 1'b0;
		repeat (6) @(posedge pclk);
	endtask : frame
endmodule : vcp_hwy_model
